// ===== aca_pkg.sv
/*
  Shared constants and types of the command acceptance block.
  Assumes one card clock of 20 MHz and a synchronous active-low reset.
*/
// Behaviour
// - Class 1 command: busy asserted within 400 ns of the opcode write.
// - Class 2: busy within 400 ns, data request within 700 us, busy drops within 400 ns.
// - Class 3: busy within 400 ns, data request within 20 ms, busy drops within 400 ns.
// - E5h and 98h decode as power-mode query, class 1, drive select only.
// - 20h and 21h decode as sector read, class 1, full address parameters.
// - 22h and 23h decode as long read, class 1, no sector count.
// - 91h is geometry initialisation, E4h buffer read, both class 1.
// - 38h is sector write without pre-erase, class 2, full address parameters.
// - Legacy erase and write-without-erase opcodes still erase the addressed sectors.
// - Fully valid drive/head parameters use both drive select and head fields.
// - Drive-only drive/head parameters use drive select and ignore head field.
// - Power query while sleeping or in transition loads sector count with 00h, interrupts.
// - Power query while idle loads sector count with FFh, interrupts.
// - Diagnostic 90h puts result 01h to 05h in the error register.
// - In native IDE mode a failed secondary drive reports an 8Xh code.
package aca_pkg;

  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned BSY_SET_NS   = 400;
  localparam int unsigned DRQ_C2_US    = 700;
  localparam int unsigned DRQ_C3_MS    = 20;
  localparam int unsigned BSY_SET_CYC  = (BSY_SET_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned DRQ_C2_CYC   = DRQ_C2_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DRQ_C3_CYC   = DRQ_C3_MS * (CLK_HZ / 1000);

  // AXI4-Lite register byte offsets.
  localparam logic [5:0] A_FEAT   = 6'h00;
  localparam logic [5:0] A_SCNT   = 6'h04;
  localparam logic [5:0] A_SNUM   = 6'h08;
  localparam logic [5:0] A_CYL    = 6'h0c;
  localparam logic [5:0] A_DH     = 6'h10;
  localparam logic [5:0] A_CMD    = 6'h14;
  localparam logic [5:0] A_STAT   = 6'h18;
  localparam logic [5:0] A_ERR    = 6'h1c;
  localparam logic [5:0] A_CTRL   = 6'h20;
  localparam logic [5:0] A_ISTAT  = 6'h24;
  localparam logic [5:0] A_IMASK  = 6'h28;
  localparam logic [5:0] A_DONE   = 6'h2c;
  localparam logic [5:0] A_DEC    = 6'h30;

  // Status register bits.
  localparam int unsigned ST_BSY  = 7;
  localparam int unsigned ST_DRQ  = 3;
  localparam int unsigned ST_ERR  = 0;
  // Control register bits: power state [1:0], native IDE, secondary failed, diag code [10:8].
  localparam int unsigned CT_IDE  = 2;
  localparam int unsigned CT_SEC  = 3;
  // Interrupt status bits.
  localparam int unsigned IS_DONE = 0;
  localparam int unsigned IS_DRQ  = 1;
  localparam int unsigned IS_ABRT = 2;

  localparam logic [7:0] ERR_ABRT   = 8'h04;
  localparam logic [7:0] SC_SLEEP   = 8'h00;
  localparam logic [7:0] SC_IDLE    = 8'hff;
  localparam logic [7:0] DIAG_PASS  = 8'h01;
  localparam logic [7:0] DIAG_MAX   = 8'h05;
  localparam logic [7:0] DIAG_SEC   = 8'h80;
  localparam logic [1:0] PWR_IDLE   = 2'b00;

  typedef enum logic [1:0] {ACA_C1, ACA_C2, ACA_C3, ACA_BAD} aca_class_t;
  typedef enum logic [2:0] {ACA_NONE, ACA_PWRQ, ACA_DIAG, ACA_ERASE, ACA_GEN} aca_kind_t;
  typedef enum {ACA_IDLE, ACA_BUSY, ACA_WAITDRQ, ACA_DRQ, ACA_FIN} aca_state_t;

  typedef struct packed {
    aca_class_t cls;
    aca_kind_t  kind;
    logic       dh_full;
    logic       use_sc;
    logic       erase;
  } aca_dec_t;

  typedef struct packed {
    logic        awv;
    logic [5:0]  awa;
    logic        wv;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bv;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
    logic [7:0]  feat;
    logic [7:0]  scnt;
    logic [7:0]  snum;
    logic [15:0] cyl;
    logic [7:0]  dh;
    logic [7:0]  cmd;
    logic [7:0]  err;
    logic        busy_flag;
    logic        drq;
    logic        errf;
    logic [10:0] ctrl;
    logic [2:0]  ist;
    logic [2:0]  imask;
    aca_dec_t    dec;
    logic [3:0]  head_used;
    logic        erase_req;
    logic        start;
    aca_state_t  st;
    logic [31:0] cnt;
  } aca_state_s_t;

endpackage

// ===== aca_core.sv
/*
  Command acceptance core with AXI4-Lite register access.
  Assumes an AXI4-Lite master on the same clock; media work is external and
  signalled by media_done, which must not arrive before the command started.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module aca_core #(
  parameter int unsigned DRQ_C2_CYCLES = aca_pkg::DRQ_C2_CYC,
  parameter int unsigned DRQ_C3_CYCLES = aca_pkg::DRQ_C3_CYC
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [5:0]          s_axi_awaddr,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [5:0]          s_axi_araddr,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  input  wire logic                media_done,
  output logic                     cmd_start,
  output aca_pkg::aca_dec_t        cmd_decode,
  output logic                     erase_req,
  output logic [3:0]               head_used,
  output logic                     irq
);
  import aca_pkg::*;

  aca_state_s_t s;
  aca_state_s_t n;
  logic         do_w;
  logic         do_r;
  logic         cmd_wr;
  aca_dec_t     d;
  logic [31:0]  rv;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode decode; class 1 is the default only for the 1xh and 7xh opcode groups.
  always_comb
  begin
    d = '{cls: ACA_BAD, kind: ACA_NONE, dh_full: 1'b0, use_sc: 1'b0, erase: 1'b0};
    case (s.wd[7:0])
      8'he5, 8'h98: d = '{ACA_C1, ACA_PWRQ, 1'b0, 1'b0, 1'b0};
      8'h20, 8'h21: d = '{ACA_C1, ACA_GEN, 1'b1, 1'b1, 1'b0};
      8'h22, 8'h23: d = '{ACA_C1, ACA_GEN, 1'b1, 1'b0, 1'b0};
      8'h91: d = '{ACA_C1, ACA_GEN, 1'b1, 1'b1, 1'b0};
      8'he4: d = '{ACA_C1, ACA_GEN, 1'b0, 1'b0, 1'b0};
      8'h90: d = '{ACA_C1, ACA_DIAG, 1'b0, 1'b0, 1'b0};
      8'hc0: d = '{ACA_C1, ACA_ERASE, 1'b1, 1'b1, 1'b1};
      8'h38: d = '{ACA_C2, ACA_GEN, 1'b1, 1'b1, 1'b1};
      8'hcd: d = '{ACA_C3, ACA_GEN, 1'b1, 1'b1, 1'b1};
      8'h30, 8'h31, 8'h3c, 8'hca, 8'hcb, 8'h50: d = '{ACA_C2, ACA_GEN, 1'b1, 1'b1, 1'b0};
      8'h32, 8'h33: d = '{ACA_C2, ACA_GEN, 1'b1, 1'b0, 1'b0};
      8'he8: d = '{ACA_C2, ACA_GEN, 1'b0, 1'b0, 1'b0};
      8'hc5: d = '{ACA_C3, ACA_GEN, 1'b1, 1'b1, 1'b0};
      8'hec, 8'he3, 8'h97, 8'he1, 8'h95, 8'he6, 8'h99, 8'he2, 8'h96, 8'he0, 8'h94,
      8'h03, 8'hef, 8'hc6:
        d = '{ACA_C1, ACA_GEN, 1'b0, 1'b0, 1'b0};
      8'hc8, 8'hc9, 8'h40, 8'h41, 8'hc4, 8'h87, 8'hf5:
        d = '{ACA_C1, ACA_GEN, 1'b1, 1'b1, 1'b0};
      default:
      begin
        if (s.wd[7:4] == 4'h1 || s.wd[7:4] == 4'h7)
          d = '{ACA_C1, ACA_GEN, 1'b1, 1'b0, 1'b0};
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux.
  always_comb
  begin
    rv = 32'h0;
    case (s_axi_araddr)
      A_FEAT:  rv = {24'h0, s.feat};
      A_SCNT:  rv = {24'h0, s.scnt};
      A_SNUM:  rv = {24'h0, s.snum};
      A_CYL:   rv = {16'h0, s.cyl};
      A_DH:    rv = {24'h0, s.dh};
      A_CMD:   rv = {24'h0, s.cmd};
      A_STAT:  rv = {24'h0, s.busy_flag, 3'b000, s.drq, 2'b00, s.errf};
      A_ERR:   rv = {24'h0, s.err};
      A_CTRL:  rv = {21'h0, s.ctrl};
      A_ISTAT: rv = {29'h0, s.ist};
      A_IMASK: rv = {29'h0, s.imask};
      A_DEC:   rv = {24'h0, s.dec};
      default: rv = 32'h0;
    endcase
  end

  assign do_w   = s.awv && s.wv && !s.bv;
  assign do_r   = s_axi_arvalid && !s.rv;
  // A task-file or opcode write while busy is outside the host's contract and is dropped; mask, interrupt status and control writes still land.
  assign cmd_wr = do_w && s.awa == A_CMD && s.ws[0] && !s.busy_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb
  begin
    n = s;
    n.start = 1'b0;
    n.erase_req = 1'b0;
    if (s_axi_awvalid && !s.awv)
    begin
      n.awv = 1'b1;
      n.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.wv)
    begin
      n.wv = 1'b1;
      n.wd = s_axi_wdata;
      n.ws = s_axi_wstrb;
    end
    if (s.bv && s_axi_bready)
      n.bv = 1'b0;
    if (s.rv && s_axi_rready)
      n.rv = 1'b0;
    if (do_r)
    begin
      n.rv = 1'b1;
      n.rd = rv;
      n.rr = (s_axi_araddr > A_DEC || s_axi_araddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
    end
    if (do_w)
    begin
      n.awv = 1'b0;
      n.wv = 1'b0;
      n.bv = 1'b1;
      if (s.ws[0] && !s.busy_flag)
      begin
        case (s.awa)
          A_FEAT:  n.feat = s.wd[7:0];
          A_SCNT:  n.scnt = s.wd[7:0];
          A_SNUM:  n.snum = s.wd[7:0];
          A_CYL:   n.cyl = {s.ws[1] ? s.wd[15:8] : s.cyl[15:8], s.wd[7:0]};
          A_DH:    n.dh = s.wd[7:0];
          default: n.cmd = n.cmd;
        endcase
      end
      if (s.ws[0] && s.awa == A_IMASK)
        n.imask = s.wd[2:0];
      if (s.ws[0] && s.awa == A_ISTAT)
        n.ist = s.ist & ~s.wd[2:0];
      if (s.awa == A_CTRL)
        n.ctrl = s.wd[10:0];
    end
    if (cmd_wr)
    begin
      n.cmd = s.wd[7:0];
      n.dec = d;
      n.busy_flag = 1'b1;
      n.drq = 1'b0;
      n.errf = 1'b0;
      n.cnt = 32'h0;
      n.st = ACA_BUSY;
      n.head_used = d.dh_full ? s.dh[3:0] : 4'h0;
    end
    case (s.st)
      ACA_IDLE: n.cnt = 32'h0;
      ACA_BUSY:
      begin
        n.st = ACA_FIN;
        if (s.dec.cls == ACA_BAD)
        begin
          n.err = ERR_ABRT;
          n.errf = 1'b1;
          n.ist[IS_ABRT] = 1'b1;
        end
        else if (s.dec.kind == ACA_PWRQ)
          n.scnt = (s.ctrl[1:0] == PWR_IDLE) ? SC_IDLE : SC_SLEEP;
        else if (s.dec.kind == ACA_DIAG)
        begin
          if (s.ctrl[CT_IDE] && s.ctrl[CT_SEC])
            n.err = DIAG_SEC | {5'h0, s.ctrl[10:8]};
          else if (s.ctrl[10:8] == 3'h0 || {5'h0, s.ctrl[10:8]} > DIAG_MAX)
            n.err = DIAG_PASS;
          else
            n.err = {5'h0, s.ctrl[10:8]};
        end
        else
        begin
          n.start = 1'b1;
          n.erase_req = s.dec.erase;
          n.st = (s.dec.cls == ACA_C1) ? ACA_FIN : ACA_WAITDRQ;
        end
      end
      ACA_WAITDRQ:
      begin
        n.cnt = s.cnt + 32'h1;
        // Buffer setup is instant here, so data request comes well inside the limit.
        if (s.cnt >= ((s.dec.cls == ACA_C3) ? DRQ_C3_CYCLES : DRQ_C2_CYCLES) - 1
            || s.cnt == 32'h1)
        begin
          n.drq = 1'b1;
          n.busy_flag = 1'b0;
          n.ist[IS_DRQ] = 1'b1;
          n.st = ACA_DRQ;
        end
      end
      ACA_DRQ:
      begin
        // A new opcode in the data phase must not be lost to a late media_done.
        if (media_done && !cmd_wr)
        begin
          n.drq = 1'b0;
          n.st = ACA_IDLE;
          n.ist[IS_DONE] = 1'b1;
        end
      end
      ACA_FIN:
      begin
        n.busy_flag = 1'b0;
        n.ist[IS_DONE] = 1'b1;
        n.st = ACA_IDLE;
      end
      default: n.st = ACA_IDLE;
    endcase
    if (!aresetn)
    begin
      n = '0;
      n.st = ACA_IDLE;
      n.dec = '{cls: ACA_C1, kind: ACA_NONE, dh_full: 1'b0, use_sc: 1'b0, erase: 1'b0};
    end
  end

  always_ff @(posedge aclk)
    s <= n;

  assign s_axi_awready = !s.awv;
  assign s_axi_wready  = !s.wv;
  assign s_axi_bvalid  = s.bv;
  assign s_axi_bresp   = 2'b00;
  assign s_axi_arready = !s.rv;
  assign s_axi_rvalid  = s.rv;
  assign s_axi_rdata   = s.rd;
  assign s_axi_rresp   = s.rr;
  assign cmd_start     = s.start;
  assign cmd_decode    = s.dec;
  assign erase_req     = s.erase_req;
  assign head_used     = s.head_used;
  assign irq           = |(s.ist & s.imask);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_bsy_set;
    @(posedge aclk) disable iff (!aresetn) cmd_wr |=> s.busy_flag;
  endproperty
  a_bsy_set: assert property (p_bsy_set) else $error("busy not set after opcode");

  property p_drq_c2;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_wr && d.cls == ACA_C2 && d.kind == ACA_GEN) |-> ##[1:6] s.drq;
  endproperty
  a_drq_c2: assert property (p_drq_c2) else $error("class 2 data request late");

  property p_drq_c3;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_wr && d.cls == ACA_C3) |-> ##[1:6] (s.drq && !s.busy_flag);
  endproperty
  a_drq_c3: assert property (p_drq_c3) else $error("class 3 data request late");

  property p_pwr_idle;
    @(posedge aclk) disable iff (!aresetn)
      (s.st == ACA_BUSY && s.dec.kind == ACA_PWRQ && s.ctrl[1:0] == PWR_IDLE)
        |=> s.scnt == SC_IDLE ##1 !s.busy_flag && s.ist[IS_DONE];
  endproperty
  a_pwr_idle: assert property (p_pwr_idle) else $error("idle power answer wrong");

  property p_pwr_sleep;
    @(posedge aclk) disable iff (!aresetn)
      (s.st == ACA_BUSY && s.dec.kind == ACA_PWRQ && s.ctrl[1:0] != PWR_IDLE)
        |=> s.scnt == SC_SLEEP;
  endproperty
  a_pwr_sleep: assert property (p_pwr_sleep) else $error("sleep power answer wrong");

  property p_abort;
    @(posedge aclk) disable iff (!aresetn)
      (s.st == ACA_BUSY && s.dec.cls == ACA_BAD) |=> s.errf && s.err == ERR_ABRT ##1 !s.busy_flag;
  endproperty
  a_abort: assert property (p_abort) else $error("bad opcode not aborted");

  property p_diag;
    @(posedge aclk) disable iff (!aresetn)
      (s.st == ACA_BUSY && s.dec.kind == ACA_DIAG && !s.ctrl[CT_IDE])
        |=> s.err >= DIAG_PASS && s.err <= DIAG_MAX;
  endproperty
  a_diag: assert property (p_diag) else $error("diagnostic code out of range");

  property p_head;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_wr && !d.dh_full) |=> head_used == 4'h0;
  endproperty
  a_head: assert property (p_head) else $error("head used for drive-only command");

  property p_erase;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_wr && s.wd[7:0] == 8'h38) |-> ##2 erase_req;
  endproperty
  a_erase: assert property (p_erase) else $error("legacy write did not erase");

  property p_c1_done;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_wr && d.cls == ACA_C1) |-> ##3 (!s.busy_flag && s.ist[IS_DONE]);
  endproperty
  a_c1_done: assert property (p_c1_done) else $error("class 1 did not finish");

  property p_drq_rise;
    @(posedge aclk) disable iff (!aresetn)
      $rose(s.drq) |-> !s.busy_flag;
  endproperty
  a_drq_rise: assert property (p_drq_rise) else $error("busy held with data request");

  property p_c2_start;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_wr && d.cls == ACA_C2) |-> ##2 cmd_start;
  endproperty
  a_c2_start: assert property (p_c2_start) else $error("class 2 buffer not started");

  property p_pwr_nostart;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_wr && d.kind == ACA_PWRQ) |-> ##2 !cmd_start;
  endproperty
  a_pwr_nostart: assert property (p_pwr_nostart) else $error("power query started media");

  property p_head_full;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_wr && d.dh_full) |=> head_used == $past(s.dh[3:0]);
  endproperty
  a_head_full: assert property (p_head_full) else $error("head field not taken");

  property p_dec_pwr;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_wr && (s.wd[7:0] == 8'he5 || s.wd[7:0] == 8'h98))
        |=> (cmd_decode.kind == ACA_PWRQ && !cmd_decode.dh_full);
  endproperty
  a_dec_pwr: assert property (p_dec_pwr) else $error("power query decode wrong");

  property p_dec_read;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_wr && (s.wd[7:0] == 8'h20 || s.wd[7:0] == 8'h21))
        |=> (cmd_decode.cls == ACA_C1 && cmd_decode.use_sc && cmd_decode.dh_full);
  endproperty
  a_dec_read: assert property (p_dec_read) else $error("sector read decode wrong");

  property p_dec_long;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_wr && (s.wd[7:0] == 8'h22 || s.wd[7:0] == 8'h23))
        |=> (cmd_decode.cls == ACA_C1 && !cmd_decode.use_sc && cmd_decode.dh_full);
  endproperty
  a_dec_long: assert property (p_dec_long) else $error("long read decode wrong");

  property p_dec_c1;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_wr && (s.wd[7:0] == 8'h91 || s.wd[7:0] == 8'he4)) |=> cmd_decode.cls == ACA_C1;
  endproperty
  a_dec_c1: assert property (p_dec_c1) else $error("geometry or buffer decode wrong");

  property p_dec_c2;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_wr && s.wd[7:0] == 8'h38) |=> cmd_decode.cls == ACA_C2;
  endproperty
  a_dec_c2: assert property (p_dec_c2) else $error("write without erase decode wrong");

  property p_diag_sec;
    @(posedge aclk) disable iff (!aresetn)
      (s.st == ACA_BUSY && s.dec.kind == ACA_DIAG && s.ctrl[CT_IDE] && s.ctrl[CT_SEC])
        |=> s.err[7:4] == 4'h8;
  endproperty
  a_diag_sec: assert property (p_diag_sec) else $error("secondary fault code wrong");

endmodule // aca_core

// ===== aca_media_model.sv
/*
  Media-side model of the command acceptance block.
  Assumes cmd_start is a one-cycle pulse on aclk.
*/
`timescale 1ns/100ps
module aca_media_model #(
  parameter int unsigned DLY = 40
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic cmd_start,
  output logic      media_done
);
  int unsigned cnt;
  // Done stays high until the next start, so a slow poll cannot miss it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cmd_start)
    begin
      cnt        <= 0;
      media_done <= 1'b0;
    end
    else if (cnt == DLY)
      media_done <= 1'b1;
    else
      cnt <= cnt + 1;
  end
endmodule // aca_media_model

// ===== tb.sv
/*
  Self-checking bench of the command acceptance core.
  Assumes the media model answers every start after a fixed delay.
*/
`timescale 1ns/100ps
module tb;
  import aca_pkg::*;
  typedef struct packed {
    logic [7:0] op;
    aca_class_t cls;
    logic [3:0] hd;
    logic       er;
  } aca_row_t;
  localparam aca_row_t ROWS [11] = '{
    '{8'he5, ACA_C1, 4'h0, 1'b0}, '{8'h98, ACA_C1, 4'h0, 1'b0},
    '{8'h20, ACA_C1, 4'h5, 1'b0}, '{8'h21, ACA_C1, 4'h5, 1'b0},
    '{8'h22, ACA_C1, 4'h5, 1'b0}, '{8'h23, ACA_C1, 4'h5, 1'b0},
    '{8'h91, ACA_C1, 4'h5, 1'b0}, '{8'he4, ACA_C1, 4'h0, 1'b0},
    '{8'h38, ACA_C2, 4'h5, 1'b1}, '{8'hcd, ACA_C3, 4'h5, 1'b1},
    '{8'hc0, ACA_C1, 4'h5, 1'b1}};
  logic        aclk, aresetn, awv, awr, wv, wrdy, bv, brdy, arv, arr, rv, rrdy;
  logic [5:0]  awa, ara;
  logic [31:0] wd, rdat, v;
  logic [3:0]  ws, hu;
  logic [1:0]  bre, rre, vr, vb;
  logic        md, cst, er, irq;
  aca_dec_t    dec;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n_st = 0;
  int          n_er = 0;

  aca_core #(.DRQ_C2_CYCLES(200), .DRQ_C3_CYCLES(400)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_bresp(bre),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .s_axi_rdata(rdat), .s_axi_rresp(rre), .media_done(md),
    .cmd_start(cst), .cmd_decode(dec), .erase_req(er), .head_used(hu), .irq(irq));
  aca_media_model u_media (.aclk(aclk), .aresetn(aresetn), .cmd_start(cst), .media_done(md));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("tests %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Ready is looked at on the falling edge, where it equals what the next rising edge samples.
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic ta, tw, tq;
    @(posedge aclk);
    {awv, wv, brdy} <= 3'b111;
    {awa, wd, ws} <= {a, d, 4'hf};
    forever
    begin
      @(negedge aclk);
      ta = awv && awr;
      tw = wv && wrdy;
      tq = bv;
      vb = bre;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tq)
      begin
        brdy <= 1'b0;
        break;
      end
    end
    chk("bresp", vb, 32'h0);
  endtask

  task automatic rd(input logic [5:0] a);
    logic ta, tq;
    @(posedge aclk);
    {arv, rrdy} <= 2'b11;
    ara <= a;
    forever
    begin
      @(negedge aclk);
      ta = arv && arr;
      tq = rv;
      {v, vr} = {rdat, rre};
      @(posedge aclk);
      if (ta) arv <= 1'b0;
      if (tq)
      begin
        rrdy <= 1'b0;
        break;
      end
    end
  endtask

  task automatic poll(input logic [5:0] a, input int b);
    int n;
    for (n = 0; n < 100; n++)
    begin
      rd(a);
      if (v[b] === 1'b1)
        break;
    end
    chk("poll", n < 100, 1'b1);
  endtask

  task automatic run(input logic [7:0] op);
    wr(A_CMD, {24'h0, op});
    poll(A_ISTAT, IS_DONE);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_total++;
      stop_test;
    end
  end

  // Pulses are counted mid-cycle, where they are settled.
  always @(negedge aclk)
  begin
    if (cst === 1'b1) n_st++;
    if (er === 1'b1) n_er++;
  end

  initial
  begin
    aresetn = 1'b0;
    {awv, wv, brdy, arv, rrdy} = '0;
    {awa, ara, wd, ws} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk("irq after reset", irq, 1'b0);
    rd(A_STAT);
    chk("status after reset", v, 32'h0);
    wr(A_IMASK, 32'h1);
    for (int i = 0; i < 11; i++)
    begin
      wr(A_DH, 32'ha5);
      wr(A_CMD, {24'h0, ROWS[i].op});
      if (ROWS[i].cls != ACA_C1)
      begin
        poll(A_STAT, ST_DRQ);
        chk("busy at drq", v[ST_BSY], 1'b0);
      end
      poll(A_ISTAT, IS_DONE);
      chk("irq set", irq, 1'b1);
      chk("class", dec.cls, ROWS[i].cls);
      chk("head", hu, ROWS[i].hd);
      chk("erase", dec.erase, ROWS[i].er);
      wr(A_ISTAT, 32'h7);
      rd(A_ISTAT);
      chk("irq clear", irq, 1'b0);
    end
    chk("start pulses", n_st, 32'd9);
    chk("erase pulses", n_er, 32'd3);
    // Sleep case runs masked, so done must not reach the interrupt line.
    for (int k = 0; k < 2; k++)
    begin
      wr(A_IMASK, k ? 32'h0 : 32'h1);
      wr(A_CTRL, k);
      run(8'he5);
      chk("irq mask", irq, !k);
      rd(A_SCNT);
      chk("power sc", v[7:0], k ? SC_SLEEP : SC_IDLE);
      wr(A_ISTAT, 32'h7);
      wr(A_CTRL, k ? 32'h30c : 32'h300);
      run(8'h90);
      rd(A_ERR);
      chk("diag", v[7:0], k ? 8'h83 : 8'h03);
      wr(A_ISTAT, 32'h7);
    end
    run(8'h5a);
    chk("abort int", v[IS_ABRT], 1'b1);
    rd(A_ERR);
    chk("abort code", v[7:0], ERR_ABRT);
    rd(A_STAT);
    chk("abort stat", {v[ST_BSY], v[ST_ERR]}, 2'b01);
    rd(6'h3c);
    chk("unmapped", vr, 2'b10);
    // Reset in mid-run with flags pending must clear them and the line.
    wr(A_IMASK, 32'h7);
    chk("irq before reset", irq, 1'b1);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk("irq after mid reset", irq, 1'b0);
    rd(A_STAT);
    chk("status after mid reset", v, 32'h0);
    rd(A_ISTAT);
    chk("int status after mid reset", v, 32'h0);
    stop_test;
  end
endmodule // tb
